//--- hft_pkg.sv
/*
 * Shared constants and types for the host frame timing counters.
 * Assumes a 50 MHz system clock and a full-speed bit rate of 12 Mbit/s.
 */
package hft_pkg;

	// Clock and bit rates in kHz; the tick generator divides by their ratio.
	localparam int CLK_KHZ = 50000;
	localparam int BIT_KHZ = 12000;
	// Accumulator step and modulus derived from the two rates.
	localparam logic [15:0] TICK_INC = 16'(BIT_KHZ);
	localparam logic [15:0] TICK_MOD = 16'(CLK_KHZ);
	// Shortest spacing of two ticks in system clocks, rounded down.
	localparam int TICK_MIN_GAP = CLK_KHZ / BIT_KHZ;

	// Command codes of the two registers.
	localparam logic [7:0] CMD_RD_TIME_LEFT = 8'h0E;
	localparam logic [7:0] CMD_WR_TIME_LEFT = 8'h8E;
	localparam logic [7:0] CMD_RD_FRAME_CNT = 8'h0F;
	localparam logic [7:0] CMD_WR_FRAME_CNT = 8'h8F;

	// Field widths and positions.
	localparam int BTL_W      = 14;
	localparam int FC_W       = 16;
	localparam int THR_W      = 11;
	localparam int TOGGLE_BIT = 31;

	// Reset values; the nominal frame period value is 11999, a frame of 12000 bit times.
	localparam logic [13:0] PERIOD_RESET    = 14'h2EDF;
	localparam logic [13:0] TIME_LEFT_RESET = 14'h0000;
	localparam logic [15:0] FRAME_CNT_RESET = 16'h0000;
	localparam logic [15:0] FRAME_CNT_MAX   = 16'hFFFF;

	// Steps taken at every frame boundary.
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_SOF  = 5'h02,
		ST_SHM  = 5'h04,
		ST_FLAG = 5'h08,
		ST_ED   = 5'h10
	} hft_seq_type;

endpackage

//--- hft_tick_if.sv
/*
 * Carries the bit time tick from the tick generator to the counters.
 * Assumes both ends run on the same system clock.
 */
interface hft_tick_if
(
	input wire logic clk_sys	// System clock.
);
	logic bit_tick;	// One-cycle pulse per full-speed bit time.

	modport gen (output bit_tick);
	modport use_side (input bit_tick);
endinterface

//--- hft_bit_tick.sv
/*
 * Bit time tick generator: a fractional accumulator makes twelve ticks
 * per fifty system clocks on average.
 * Assumes srst is synchronous to clk_sys.
 */
module hft_bit_tick
	import hft_pkg::*;
(
	input wire logic clk_sys,	// System clock.
	input wire logic srst,	// Synchronous reset, active high.
	hft_tick_if.gen  tick	// Tick towards the counters.
);
	logic [15:0] acc_reg;	// Phase accumulator.
	logic [15:0] acc_next;	// Next phase.
	logic        tick_reg;	// Registered tick.
	logic        tick_next;	// Next tick.

	// The 50/12 ratio is not whole, so ticks jitter by one clock; the
	// average rate is exact, which is what frame length depends on.
	always_comb
	begin
		acc_next  = acc_reg + TICK_INC;
		tick_next = 1'b0;
		if (acc_next >= TICK_MOD)
		begin
			acc_next  = acc_next - TICK_MOD;
			tick_next = 1'b1;
		end
	end

	// Register the accumulator and the tick.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			acc_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end
		else
		begin
			acc_reg  <= acc_next;
			tick_reg <= tick_next;
		end
	end

	assign tick.bit_tick = tick_reg;

	// Ticks never come closer than four clocks apart.
	property p_tick_gap;
		@(posedge clk_sys) disable iff (srst)
		tick_reg |=> !tick_reg [*3];
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("bit ticks closer than the bit period");
endmodule

//--- hft_frame_timer.sv
/*
 * Frame timing counters of a full/low-speed host controller: the
 * bit-time-left down counter, the frame counter, the frame boundary
 * sequence and the command-code register access.
 * Assumes command, handshake and state inputs are synchronous to clk_sys.
 */
module hft_frame_timer
	import hft_pkg::*;
(
	input  wire logic              clk_sys,	// System clock, 50 MHz.
	input  wire logic              srst,	// Synchronous reset, high.
	input  wire logic              cmd_valid,	// Command strobe, one cycle.
	input  wire logic [7:0]        cmd_code,	// Read or write command code.
	input  wire logic [31:0]       cmd_wdata,	// Write data.
	output logic      [31:0]       cmd_rdata,	// Read data, registered.
	output logic                   cmd_rvalid,	// Read data valid pulse.
	input  wire logic              running_state,	// Level: frames run.
	input  wire logic              controller_reset_cmd,	// Reset pulse.
	input  wire logic              period_wr,	// Frame period write pulse.
	input  wire logic [BTL_W-1:0]  period_value,	// New frame period.
	input  wire logic              period_toggle_in,	// Its toggle bit.
	input  wire logic [THR_W-1:0]  lowspeed_threshold,	// Threshold.
	input  wire logic              ls_req,	// Low-speed transaction asks.
	output logic                   ls_go,	// Low-speed start allowed.
	output logic                   sof_req,	// Send start-of-frame.
	input  wire logic              sof_done,	// Start-of-frame was sent.
	output logic                   host_shared_area_wr,	// Write request.
	output logic      [FC_W-1:0]   host_shared_area_data,	// Count written.
	input  wire logic              host_shared_area_ack,	// Write done.
	output logic                   frame_start_flag_set,	// Flag pulse.
	output logic                   ed_fetch_ok,	// First descriptor may go.
	output logic      [BTL_W-1:0]  bit_time_left	// Counter value.
);
	// All checks below share this clock and are off during reset.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	// Increment with natural roll-over at the counter width.
	function automatic logic [FC_W-1:0] fc_inc(input logic [FC_W-1:0] v);
		fc_inc = v + 16'h0001;
	endfunction

	hft_tick_if tick_bus (.clk_sys(clk_sys));	// Bit tick carrier.

	// The tick generator sits beside the counters on the same clock.
	hft_bit_tick hft_bit_tick_i
	(
		.clk_sys (clk_sys),
		.srst    (srst),
		.tick    (tick_bus.gen)
	);

	logic              bit_tick;	// Bit time pulse.
	logic [BTL_W-1:0]  btl_reg;	// Bit-time-left counter.
	logic [BTL_W-1:0]  btl_next;	// Its next value.
	logic              left_toggle_reg;	// Toggle copied at reload.
	logic              left_toggle_next;	// Its next value.
	logic [FC_W-1:0]   frame_count_reg;	// Frame counter.
	logic [FC_W-1:0]   frame_count_next;	// Its next value.
	logic [BTL_W-1:0]  frame_period_reg;	// Programmed frame period.
	logic [BTL_W-1:0]  frame_period_next;	// Its next value.
	logic              period_toggle_reg;	// Period toggle bit.
	logic              period_toggle_next;	// Its next value.
	logic              run_q_reg;	// Running state one cycle ago.
	logic              wr_left;	// Software writes remaining time.
	logic              run_rise;	// Running state entered.
	logic              frame_edge;	// Counter reload at zero.
	logic              new_frame;	// Any frame boundary.
	logic [31:0]       rdata_next;	// Next read data.
	logic              rvalid_next;	// Next read valid.
	logic              ls_go_next;	// Next low-speed permission.

	assign bit_tick   = tick_bus.bit_tick;
	assign wr_left    = cmd_valid && (cmd_code == CMD_WR_TIME_LEFT);
	assign run_rise   = running_state && !run_q_reg;
	// A software write in the same cycle wins over the reload.
	assign frame_edge = running_state && run_q_reg && bit_tick &&
		!wr_left && (btl_reg == TIME_LEFT_RESET);
	assign new_frame  = run_rise || frame_edge;

	// Next values of the counters, the period and the read port.
	always_comb
	begin
		btl_next           = btl_reg;
		left_toggle_next   = left_toggle_reg;
		frame_count_next   = frame_count_reg;
		frame_period_next  = frame_period_reg;
		period_toggle_next = period_toggle_reg;
		rdata_next         = cmd_rdata;
		rvalid_next        = 1'b0;
		// A period value takes effect at the next entry or reload, its toggle bit only at the next reload.
		if (controller_reset_cmd)
			frame_period_next = PERIOD_RESET;
		else if (period_wr)
		begin
			frame_period_next  = period_value;
			period_toggle_next = period_toggle_in;
		end
		// Counter: software write, entry, reload, or plain decrement.
		if (wr_left)
		begin
			btl_next         = cmd_wdata[BTL_W-1:0];
			left_toggle_next = cmd_wdata[TOGGLE_BIT];
		end
		else if (run_rise)
			btl_next = frame_period_reg;
		else if (frame_edge)
		begin
			btl_next         = frame_period_reg;
			left_toggle_next = period_toggle_reg;
		end
		else if (running_state && bit_tick)
			btl_next = btl_reg - 14'h0001;
		// The frame counter only moves at boundaries; 8F writes drop.
		if (new_frame)
			frame_count_next = fc_inc(frame_count_reg);
		// Reads answer in the next cycle; other codes are not ours.
		if (cmd_valid && (cmd_code == CMD_RD_TIME_LEFT))
		begin
			rdata_next  = {left_toggle_reg, 17'h00000, btl_reg};
			rvalid_next = 1'b1;
		end
		else if (cmd_valid && (cmd_code == CMD_RD_FRAME_CNT))
		begin
			rdata_next  = {16'h0000, frame_count_reg};
			rvalid_next = 1'b1;
		end
		// Low-speed start only with enough of the frame left.
		ls_go_next = ls_req && running_state &&
			(btl_reg >= {3'h0, lowspeed_threshold});
	end

	// Register the counters; an 8F write is accepted and has no effect.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			btl_reg           <= TIME_LEFT_RESET;
			left_toggle_reg   <= 1'b0;
			frame_count_reg   <= FRAME_CNT_RESET;
			frame_period_reg  <= PERIOD_RESET;
			period_toggle_reg <= 1'b0;
			run_q_reg         <= 1'b0;
			cmd_rdata         <= 32'h00000000;
			cmd_rvalid        <= 1'b0;
			ls_go             <= 1'b0;
		end
		else
		begin
			btl_reg           <= btl_next;
			left_toggle_reg   <= left_toggle_next;
			frame_count_reg   <= frame_count_next;
			frame_period_reg  <= frame_period_next;
			period_toggle_reg <= period_toggle_next;
			run_q_reg         <= running_state;
			cmd_rdata         <= rdata_next;
			cmd_rvalid        <= rvalid_next;
			ls_go             <= ls_go_next;
		end
	end

	assign bit_time_left = btl_reg;

	hft_seq_type seq_reg;	// Frame boundary step.
	hft_seq_type seq_next;	// Next step.
	logic        sof_next;	// Next start-of-frame request.
	logic        shm_next;	// Next shared area write request.
	logic [FC_W-1:0] shm_data_next;	// Next shared area data.
	logic        flag_next;	// Next flag pulse.
	logic        ed_next;	// Next descriptor permission.

	// Boundary sequence: send SOF, store the count, flag, then allow
	// descriptor fetch. A boundary restarts it; frames are far longer.
	always_comb
	begin
		seq_next      = seq_reg;
		shm_data_next = host_shared_area_data;
		case (seq_reg)
			ST_IDLE:
				if (new_frame)
					seq_next = ST_SOF;
			ST_SOF:
				if (sof_done)
					seq_next = ST_SHM;
			ST_SHM:
				if (host_shared_area_ack)
					seq_next = ST_FLAG;
			ST_FLAG:
				seq_next = ST_ED;
			ST_ED:
				seq_next = ST_IDLE;
			default:
				seq_next = ST_IDLE;
		endcase
		if (new_frame)
			seq_next = ST_SOF;
		if (seq_next == ST_SHM)
			shm_data_next = frame_count_reg;
		sof_next  = (seq_next == ST_SOF);
		shm_next  = (seq_next == ST_SHM);
		flag_next = (seq_next == ST_FLAG);
		ed_next   = (seq_next == ST_ED);
	end

	// Register the step and its outputs.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			seq_reg               <= ST_IDLE;
			sof_req               <= 1'b0;
			host_shared_area_wr   <= 1'b0;
			host_shared_area_data <= FRAME_CNT_RESET;
			frame_start_flag_set  <= 1'b0;
			ed_fetch_ok           <= 1'b0;
		end
		else
		begin
			seq_reg               <= seq_next;
			sof_req               <= sof_next;
			host_shared_area_wr   <= shm_next;
			host_shared_area_data <= shm_data_next;
			frame_start_flag_set  <= flag_next;
			ed_fetch_ok           <= ed_next;
		end
	end

	property p_decrement;
		running_state && run_q_reg && bit_tick && !wr_left &&
		(btl_reg != 14'h0000) |=> btl_reg == $past(btl_reg) - 14'h0001;
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("counter did not decrement on a bit time");

	property p_reload;
		frame_edge |=> (btl_reg == $past(frame_period_reg)) &&
			(left_toggle_reg == $past(period_toggle_reg));
	endproperty
	a_reload: assert property (p_reload)
		else $error("reload value or toggle copy wrong");

	property p_enter;
		run_rise && !wr_left |=> btl_reg == $past(frame_period_reg) &&
			frame_count_reg == $past(frame_count_reg) + 16'h0001;
	endproperty
	a_enter: assert property (p_enter)
		else $error("entering running state did not load or count");

	property p_wrap;
		new_frame && frame_count_reg == FRAME_CNT_MAX |=>
			frame_count_reg == FRAME_CNT_RESET;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("frame counter did not wrap to zero");

	property p_count_hold;
		!new_frame |=> $stable(frame_count_reg);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("frame counter moved outside a boundary");

	sequence s_shm_done;
		host_shared_area_wr && host_shared_area_ack && !new_frame;
	endsequence
	sequence s_flag_then_ed;
		frame_start_flag_set && !ed_fetch_ok ##1 ed_fetch_ok;
	endsequence
	property p_order;
		s_shm_done |=> s_flag_then_ed;
	endproperty
	a_order: assert property (p_order)
		else $error("flag or descriptor step out of order");

	property p_shm_data;
		host_shared_area_wr |-> host_shared_area_data == frame_count_reg;
	endproperty
	a_shm_data: assert property (p_shm_data)
		else $error("shared area data is not the frame count");

	property p_ls;
		ls_go |-> $past(btl_reg) >= {3'h0, $past(lowspeed_threshold)};
	endproperty
	a_ls: assert property (p_ls)
		else $error("low-speed start below threshold");

	property p_read_left;
		cmd_valid && cmd_code == CMD_RD_TIME_LEFT |=> cmd_rvalid &&
			cmd_rdata[13:0] == $past(btl_reg);
	endproperty
	a_read_left: assert property (p_read_left)
		else $error("remaining time read returned wrong data");

	property p_period_reset;
		controller_reset_cmd |=> frame_period_reg == PERIOD_RESET;
	endproperty
	a_period_reset: assert property (p_period_reset)
		else $error("controller reset did not restore the period");
endmodule

//--- tb_hft_frame_timer.sv
/*
 * Self-checking bench for the host frame timing counters: command reads
 * and writes, frame countdown, frame count and frame boundary handshake.
 * Assumes hft_pkg, hft_tick_if and the design files are compiled first.
 */
module tb_hft_frame_timer;
	timeunit 1ns;
	timeprecision 100ps;
	import hft_pkg::*;

	logic              clk_sys;	// System clock.
	logic              srst;	// Synchronous reset.
	logic              cmd_valid;	// Command strobe.
	logic [7:0]        cmd_code;	// Command code.
	logic [31:0]       cmd_wdata;	// Write data.
	logic [31:0]       cmd_rdata;	// Read data.
	logic              cmd_rvalid;	// Read data valid.
	logic              running_state;	// Frames run.
	logic              controller_reset_cmd;	// Period restore pulse.
	logic              period_wr;	// Period write pulse.
	logic [BTL_W-1:0]  period_value;	// New period.
	logic              period_toggle_in;	// Its toggle.
	logic [THR_W-1:0]  lowspeed_threshold;	// Low-speed threshold.
	logic              ls_req;	// Low-speed request.
	logic              ls_go;	// Low-speed start allowed.
	logic              sof_req;	// Start-of-frame request.
	logic              sof_done;	// Start-of-frame answer.
	logic              host_shared_area_wr;	// Shared area write.
	logic [FC_W-1:0]   host_shared_area_data;	// Count to store.
	logic              host_shared_area_ack;	// Shared area answer.
	logic              frame_start_flag_set;	// Flag pulse.
	logic              ed_fetch_ok;	// Descriptor may go.
	logic [BTL_W-1:0]  bit_time_left;	// Counter value.

	int                bad_count;	// Mismatches seen.
	int                samples_checked;	// Comparisons made.
	int                cyc;	// Clock cycles since start.
	int                exp_fc;	// Expected frame count.
	int                seqs;	// Shared area writes seen.
	int                sofs;	// Start-of-frame requests seen.
	int                flags;	// Flag pulses seen.
	int                eds;	// Descriptor pulses seen.
	int                last_flag;	// Cycle of the last flag pulse.
	logic [BTL_W-1:0]  exp_period;	// Period that the next load uses.
	logic [BTL_W-1:0]  prev_btl;	// Counter at the last falling edge.
	logic              ra;	// Running one falling edge ago.
	logic              rb;	// Running two falling edges ago.
	logic              ls_exp;	// Expected low-speed grant.
	logic              sa_prev;	// Shared area write one edge ago.
	logic [31:0]       rd;	// Data returned by a read.

	hft_frame_timer hft_frame_timer_i (.*);

	// Free-running 50 MHz clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// One compare for every kind of value; flags are zero-extended.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single closing point for both the normal end and a hang.
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Write command: one strobe cycle, no answer expected.
	task automatic cmd_wr(input logic [7:0] code, input logic [31:0] d);
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_code  = code;
		cmd_wdata = d;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
	endtask

	// Read command: the answer pulse must stand exactly one cycle later.
	task automatic cmd_rd(input logic [7:0] code, input logic ev,
		output logic [31:0] d);
		cmd_wr(code, 32'h0000_0000);
		chk({31'h0, cmd_rvalid}, {31'h0, ev});
		d = cmd_rdata;
	endtask

	// Frame period port pulse; the reset pulse may ride along.
	task automatic set_period(input logic [13:0] v, input logic t,
		input logic rst);
		@(posedge clk_sys);
		#1;
		period_wr = 1'b1;
		period_value = v;
		period_toggle_in = t;
		controller_reset_cmd = rst;
		@(posedge clk_sys);
		#1;
		period_wr = 1'b0;
		controller_reset_cmd = 1'b0;
	endtask

	// Run frames for n cycles, then stop and let the sequence settle.
	task automatic run_for(input int n);
		@(posedge clk_sys);
		#1;
		running_state = 1'b1;
		repeat (n) @(posedge clk_sys);
		#1;
		running_state = 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask

	// Far side of the frame handshake answers at once and holds its level.
	always @(posedge clk_sys)
	begin
		#1;
		sa_prev = host_shared_area_ack;
		if (sof_req && !sof_done)
			sofs++;
		sof_done = sof_req;
		host_shared_area_ack = host_shared_area_wr;
		if (host_shared_area_wr && !sa_prev)
		begin
			seqs++;
			chk({16'h0, host_shared_area_data}, exp_fc[31:0]);
		end
	end

	// Countdown watcher: values are settled at the falling edge.
	always @(negedge clk_sys)
	begin
		if (!srst)
		begin
			chk({31'h0, ls_go}, {31'h0, ls_exp});
			if (frame_start_flag_set)
			begin
				flags++;
				if (last_flag != 0)
					chk(32'(((cyc - last_flag) * 12 -
						(int'(exp_period) + 1) * 50) / 61), 0);
				last_flag = cyc;
			end
			if (ed_fetch_ok)
				eds++;
			if (!running_state)
				last_flag = 0;
			if (running_state && ra && !rb)
			begin
				exp_fc++;
				chk({18'h0, bit_time_left}, {18'h0, exp_period});
			end
			else if (running_state && ra && rb && bit_time_left != prev_btl)
			begin
				if (prev_btl == 14'h0000)
				begin
					exp_fc++;
					chk({18'h0, bit_time_left}, {18'h0, exp_period});
				end
				else
					chk({18'h0, bit_time_left}, {18'h0, prev_btl - 14'h0001});
			end
		end
		ls_exp = !srst && ls_req && running_state &&
			(bit_time_left >= {3'h0, lowspeed_threshold});
		prev_btl = bit_time_left;
		rb = ra;
		ra = running_state;
	end

	// Hang guard: the tests need well under two thousand cycles.
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc >= 5000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	// Main sequence.
	initial
	begin
		{cmd_valid, cmd_code, cmd_wdata, running_state} = '0;
		{controller_reset_cmd, period_wr, period_value} = '0;
		{period_toggle_in, ls_req, sof_done, host_shared_area_ack} = '0;
		{bad_count, samples_checked, cyc, exp_fc, seqs, flags, eds, sofs} = '0;
		{last_flag, ra, rb, ls_exp, sa_prev} = '0;
		lowspeed_threshold = 11'h003;
		exp_period = PERIOD_RESET;
		prev_btl = 14'h0000;
		srst = 1'b1;
		repeat (16) @(posedge clk_sys);
		#1;
		srst = 1'b0;
		// Reset values of both registers.
		cmd_rd(8'h0E, 1'b1, rd);
		chk(rd, 32'h0000_0000);
		cmd_rd(8'h0F, 1'b1, rd);
		chk(rd, 32'h0000_0000);
		// Reserved bits read back as zero; the toggle bit is writable.
		cmd_wr(8'h8E, 32'hFFFF_FFFF);
		cmd_rd(8'h0E, 1'b1, rd);
		chk(rd, 32'h8000_3FFF);
		// Frame count ignores writes; an unmapped code gets no answer.
		cmd_wr(8'h8F, 32'h0000_1234);
		cmd_rd(8'h0F, 1'b1, rd);
		chk(rd, 32'h0000_0000);
		cmd_rd(8'h0D, 1'b0, rd);
		// Short frames with toggle set; low-speed request stays up.
		cmd_wr(8'h8E, 32'h0000_0000);
		set_period(14'h0005, 1'b1, 1'b0);
		exp_period = 14'h0005;
		ls_req = 1'b1;
		run_for(150);
		cmd_rd(8'h0E, 1'b1, rd);
		chk({31'h0, rd[31]}, 32'h0000_0001);
		// New period while stopped, toggle inverted back.
		set_period(14'h0007, 1'b0, 1'b0);
		exp_period = 14'h0007;
		ls_req = 1'b0;
		run_for(150);
		cmd_rd(8'h0E, 1'b1, rd);
		chk({31'h0, rd[31]}, 32'h0000_0000);
		cmd_rd(8'h0F, 1'b1, rd);
		chk(rd, exp_fc[31:0]);
		// Controller reset beats a period write in the same cycle.
		set_period(14'h0003, 1'b1, 1'b1);
		exp_period = PERIOD_RESET;
		run_for(40);
		chk(flags, seqs);
		chk(eds, seqs);
		chk(seqs, exp_fc);
		chk(sofs, seqs);
		tally_and_finish();
	end
endmodule
